// File: cpu_power_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Core side: halt, wait and wake requests
// ----------------------------------------
module cpu_power_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tickIrq,     // Raw tick request
  input wire logic activeHalt,
  input wire logic fullHalt,
  input wire logic haltReq,     // Bench runs a halt instruction
  input wire logic waitReq,     // Bench runs a wait instruction
  input wire logic wakeReq,     // Bench raises an external interrupt
  output logic waitMode,
  output logic haltExec,
  output logic haltExitWake
);
  logic waitMode_q, haltExec_q, wake_q;
  // Halt only from run; wake only while halted
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      waitMode_q <= 1'h0;
      haltExec_q <= 1'h0;
      wake_q <= 1'h0;
    end
    else
    begin
      haltExec_q <= haltReq && !activeHalt && !fullHalt;
      wake_q <= wakeReq && (activeHalt || fullHalt);
      // Mask taken as open, so any tick request ends wait
      waitMode_q <= !tickIrq && (waitReq || waitMode_q);
    end
  end
  assign waitMode = waitMode_q;
  assign haltExec = haltExec_q;
  assign haltExitWake = wake_q;
endmodule

// File: main_clock_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checks: bus answer and power states
// ----------------------------------------
module main_clock_checker
  import main_clock_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic haltExec,
  input wire logic haltExitWake,
  input wire logic cpuClkEn,
  input wire logic activeHalt,
  input wire logic fullHalt,
  input wire logic clockOutPin,
  input wire logic clockOutOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Request taken, then a single-cycle answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer missing or too long");
  a_write_zero: assert property (wb_ack_o && $past(wb_we_i) |-> !wb_dat_o)
    else $error("write answer carries data");
  a_halt_entry: assert property (
    haltExec && !activeHalt && !fullHalt |=> activeHalt || fullHalt)
    else $error("halt not entered");
  a_halt_single: assert property (!(activeHalt && fullHalt))
    else $error("both halt states at once");
  a_halt_holds: assert property (fullHalt && !haltExitWake |=> fullHalt)
    else $error("full halt left without wake");
  a_wake_exit: assert property (
    (activeHalt || fullHalt) && haltExitWake |=> !activeHalt && !fullHalt)
    else $error("wake did not end halt");
  a_halt_no_cpu: assert property (
    (activeHalt || fullHalt) && $past(activeHalt || fullHalt) |-> !cpuClkEn)
    else $error("cpu clock runs in halt");
  a_no_clock_out: assert property (activeHalt [*2] |-> !clockOutPin)
    else $error("clock out active in active halt");
  a_gpio_idle: assert property (!clockOutOe [*2] |-> !clockOutPin)
    else $error("clock out pin moves while unselected");
endmodule
bind main_clock_ctrl_tick_tone main_clock_checker main_clock_checker_inst (
  .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .haltExec(haltExec), .haltExitWake(haltExitWake), .cpuClkEn(cpuClkEn),
  .activeHalt(activeHalt), .fullHalt(fullHalt),
  .clockOutPin(clockOutPin), .clockOutOe(clockOutOe));

// File: main_clock_ctrl_tick_tone.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1 - Tick period 16000/32000/80000/200000 by select
// R2 - New time base applies after current period
// R3 - Period end sets flag; status read clears
// R4 - Interrupt request only while enable set
// R5 - Halt with enable set gives active-halt
// R6 - Tick wakes wait and active-halt, not halt
// R7 - Wait mode leaves everything running
// R8 - Active-halt: counter runs, registers frozen
// R9 - Halt freezes all until halt-exit wake
// R10 - Clock-out select drives cpu clock out
// R11 - No clock-out during active-halt
// R12 - Slow divider gives osc/2, /4, /8, /16
// R13 - Slow mode off means cpu equals osc
// R14 - Tone off, ~2 kHz, ~1 kHz, ~500 Hz
// R15 - Tone keeps running in active-halt
// R16 - Software writes zero to reserved tone bits
// R17 - Software avoids bit set/clear on status
// R18 - Tick on clearing read keeps flag set
// R19 - Tone rate fixed from osc, not cpu
module main_clock_ctrl_tick_tone
  import main_clock_pkg::*;
#(
  parameter int TB_DIV_0 = TB_DIV0,
  parameter int TB_DIV_1 = TB_DIV1,
  parameter int TB_DIV_2 = TB_DIV2,
  parameter int TB_DIV_3 = TB_DIV3,
  parameter int TONE_HALF_1 = TONE1_HALF,
  parameter int TONE_HALF_2 = TONE2_HALF,
  parameter int TONE_HALF_3 = TONE3_HALF
)(
  input wire logic clk,               // Oscillator clock, undivided
  input wire logic rst_b,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic waitMode,          // Core is in wait mode
  input wire logic haltExec,          // Halt instruction, one pulse
  input wire logic haltExitWake,      // Wake with halt-exit capability
  output logic tickIrq,               // Tick interrupt request level
  output logic cpuClkEn,              // One pulse per cpu clock
  output logic activeHalt,
  output logic fullHalt,
  output logic clockOutPin,
  output logic clockOutOe,
  output logic tonePin,
  output logic toneOe
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  localparam int CW = 18;
  if (TB_DIV_0 < 2 || TB_DIV_3 >= (1 << CW) || TB_DIV_1 < 2 ||
      TB_DIV_2 < 2 || TB_DIV_1 >= (1 << CW) || TB_DIV_2 >= (1 << CW))
  begin : g_chk_tb
    $error("Time base divisions out of range");
  end
  if (TONE_HALF_1 < 1 || TONE_HALF_2 < 1 || TONE_HALF_3 < 1 ||
      TONE_HALF_1 >= (1 << 16) || TONE_HALF_2 >= (1 << 16) ||
      TONE_HALF_3 >= (1 << 16))
  begin : g_chk_tone
    $error("Tone divisions out of range");
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic ackD, ackQ;                   // Registered acknowledge
  logic [31:0] datD, datQ;            // Registered read data
  logic rdStatus;                     // Status read taken this edge
  logic wrStatus, wrTone;             // Writes taken this edge
  logic [7:0] statusView;             // Status as software sees it
  logic [7:0] csrQ;                   // Control bits, flag excluded
  logic [7:0] csrD;
  logic [1:0] toneSelQ, toneSelD;     // tone_select
  logic flagQ, flagD;                 // tick_flag
  logic frozen;                       // Registers frozen by halts
  logic tickEvt;                      // Time base period end

  // Answer one cycle after the request, drop ack the next cycle
  always_comb
  begin
    ackD = wb_cyc_i & wb_stb_i & ~ackQ;
    datD = 32'h0000_0000;
    rdStatus = 1'b0;
    wrStatus = 1'b0;
    wrTone = 1'b0;
    if (ackD)
    begin
      case (wb_adr_i)
        {CLOCK_CTRL_STATUS_IDX, 2'b00}:
        begin
          datD = {24'h00_0000, statusView};
          rdStatus = ~wb_we_i & ~frozen;
          wrStatus = wb_we_i & wb_sel_i[0] & ~frozen;
        end
        {TONE_CTRL_IDX, 2'b00}:
        begin
          // Reserved tone bits read back as zero
          datD = {30'h0000_0000, toneSelQ};
          wrTone = wb_we_i & wb_sel_i[0] & ~frozen;
        end
        default:
        begin
          // Unmapped: acked, reads zero, writes dropped
          datD = 32'h0000_0000;
        end
      endcase
    end
    if (wb_we_i)
    begin
      datD = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ackQ <= 1'b0;
      datQ <= 32'h0000_0000;
    end
    else
    begin
      ackQ <= ackD;
      datQ <= datD;
    end
  end
  assign wb_ack_o = ackQ;
  assign wb_dat_o = datQ;

  // ----------------------------------------
  // Control and status registers
  // ----------------------------------------
  assign statusView = {csrQ[7:1], flagQ};

  // Writes land with the ack; the flag bit ignores writes
  always_comb
  begin
    csrD = csrQ;
    toneSelD = toneSelQ;
    flagD = flagQ;
    if (wrStatus)
    begin
      csrD = {wb_dat_i[7:1], 1'b0};
    end
    if (wrTone)
    begin
      toneSelD = wb_dat_i[TONE_SELECT_LSB +: 2]; // R16
    end
    // Read clears, but a tick in the same cycle wins
    if (rdStatus)
    begin
      flagD = 1'b0;                   // R3
    end
    if (tickEvt)
    begin
      flagD = 1'b1;                   // R3 R18
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      csrQ <= {CLOCK_CTRL_STATUS_RST[7:1], 1'b0};
      toneSelQ <= TONE_CTRL_RST;
      flagQ <= CLOCK_CTRL_STATUS_RST[TICK_FLAG_BIT];
    end
    else
    begin
      csrQ <= csrD;
      toneSelQ <= toneSelD;
      flagQ <= flagD;
    end
  end

  logic clockOutSel, slowMode, irqEn;
  logic [1:0] slowDiv, tbSel;
  assign clockOutSel = csrQ[CLOCK_OUT_SELECT_BIT];
  assign slowDiv = csrQ[SLOW_DIVIDER_LSB +: 2];
  assign slowMode = csrQ[SLOW_MODE_SELECT_BIT];
  assign tbSel = csrQ[TIME_BASE_LSB +: 2];
  assign irqEn = csrQ[TICK_IRQ_ENABLE_BIT];

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  pwr_state_t pwrQ, pwrD;
  logic irqD, irqQ;

  // Wait mode is not tracked: nothing here changes in it
  always_comb
  begin
    pwrD = pwrQ;                      // R7
    irqD = flagQ & irqEn;             // R4
    case (pwrQ)
      PWR_RUN:
      begin
        if (haltExec)
        begin
          // Enable chooses active-halt over full halt
          pwrD = irqEn ? PWR_ACTIVE_HALT : PWR_HALT; // R5
        end
      end
      PWR_ACTIVE_HALT:
      begin
        // Tick request or any halt-exit wake ends it
        if ((flagQ & irqEn) | haltExitWake)
        begin
          pwrD = PWR_RUN;             // R6
        end
      end
      PWR_HALT:
      begin
        // Tick cannot arrive here: its counter is stopped
        if (haltExitWake)
        begin
          pwrD = PWR_RUN;             // R6 R9
        end
      end
      default:
      begin
        pwrD = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwrQ <= PWR_RUN;
      irqQ <= 1'b0;
    end
    else
    begin
      pwrQ <= pwrD;
      irqQ <= irqD;
    end
  end
  assign frozen = pwrQ != PWR_RUN;    // R8 R9
  assign tickIrq = irqQ;              // R4
  // One-hot state bits, so these come straight from the flops
  assign activeHalt = pwrQ[1];
  assign fullHalt = pwrQ[2];
  // waitMode needs no action; read to document intent
  logic unusedWait;
  assign unusedWait = waitMode;

  // ----------------------------------------
  // Time base counter
  // ----------------------------------------
  logic [CW-1:0] tbCntQ, tbCntD;
  logic [1:0] tbActQ, tbActD;         // Time base in force
  logic [CW-1:0] tbLast;

  // Last count of the period now running
  always_comb
  begin
    case (tbActQ)
      2'b00: tbLast = CW'(TB_DIV_0 - 1); // R1
      2'b01: tbLast = CW'(TB_DIV_1 - 1); // R1
      2'b10: tbLast = CW'(TB_DIV_2 - 1); // R1
      default: tbLast = CW'(TB_DIV_3 - 1); // R1
    endcase
  end

  // Stops only in full halt; a new select waits for the wrap
  always_comb
  begin
    tbCntD = tbCntQ;
    tbActD = tbActQ;
    tickEvt = 1'b0;
    if (pwrQ != PWR_HALT)             // R8 R9
    begin
      if (tbCntQ >= tbLast)
      begin
        tbCntD = '0;
        tickEvt = 1'b1;
        tbActD = tbSel;               // R2
      end
      else
      begin
        tbCntD = tbCntQ + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tbCntQ <= '0;
      tbActQ <= CLOCK_CTRL_STATUS_RST[TIME_BASE_LSB +: 2];
    end
    else
    begin
      tbCntQ <= tbCntD;
      tbActQ <= tbActD;
    end
  end

  // ----------------------------------------
  // Cpu clock divider and clock-out pin
  // ----------------------------------------
  logic [3:0] cpuCntQ, cpuCntD;
  logic [3:0] cpuLast;
  logic cpuEnD, cpuEnQ;
  logic coPinD, coPinQ, coOeD, coOeQ;

  // Enable pulse per cpu clock; pin toggles each pulse,
  // so the pin shows half the cpu rate (a flop cannot
  // forward the oscillator itself)
  always_comb
  begin
    case (slowDiv)
      2'b00: cpuLast = 4'h1;          // R12
      2'b01: cpuLast = 4'h3;          // R12
      2'b10: cpuLast = 4'h7;          // R12
      default: cpuLast = 4'hf;        // R12
    endcase
    if (!slowMode)
    begin
      cpuLast = 4'h0;                 // R13
    end
    cpuCntD = cpuCntQ + 4'h1;
    cpuEnD = 1'b0;
    if (cpuCntQ >= cpuLast)
    begin
      cpuCntD = 4'h0;
      cpuEnD = pwrQ == PWR_RUN;
    end
    coOeD = clockOutSel;              // R10
    coPinD = coPinQ;
    if (!clockOutSel || pwrQ == PWR_ACTIVE_HALT)
    begin
      coPinD = 1'b0;                  // R10 R11
    end
    else if (cpuEnD)
    begin
      coPinD = ~coPinQ;               // R10
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpuCntQ <= 4'h0;
      cpuEnQ <= 1'b0;
      coPinQ <= 1'b0;
      coOeQ <= 1'b0;
    end
    else
    begin
      cpuCntQ <= cpuCntD;
      cpuEnQ <= cpuEnD;
      coPinQ <= coPinD;
      coOeQ <= coOeD;
    end
  end
  assign cpuClkEn = cpuEnQ;
  assign clockOutPin = coPinQ;
  assign clockOutOe = coOeQ;

  // ----------------------------------------
  // Tone generator
  // ----------------------------------------
  logic [15:0] toneCntQ, toneCntD, toneLast;
  logic tonePinD, tonePinQ, toneOeD, toneOeQ;

  // Fixed divide of osc clock; keeps running in active-halt
  always_comb
  begin
    case (toneSelQ)
      2'b01: toneLast = 16'(TONE_HALF_1 - 1); // R14 R19
      2'b10: toneLast = 16'(TONE_HALF_2 - 1); // R14 R19
      default: toneLast = 16'(TONE_HALF_3 - 1); // R14 R19
    endcase
    toneCntD = toneCntQ;
    tonePinD = tonePinQ;
    toneOeD = toneSelQ != 2'b00;      // R14
    if (toneSelQ == 2'b00)
    begin
      toneCntD = 16'h0000;            // R14
      tonePinD = 1'b0;
    end
    else if (pwrQ != PWR_HALT)        // R15 R9
    begin
      if (toneCntQ >= toneLast)
      begin
        toneCntD = 16'h0000;
        tonePinD = ~tonePinQ;         // R14
      end
      else
      begin
        toneCntD = toneCntQ + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      toneCntQ <= 16'h0000;
      tonePinQ <= 1'b0;
      toneOeQ <= 1'b0;
    end
    else
    begin
      toneCntQ <= toneCntD;
      tonePinQ <= tonePinD;
      toneOeQ <= toneOeD;
    end
  end
  assign tonePin = tonePinQ;
  assign toneOe = toneOeQ;
endmodule

// File: main_clock_pkg.sv
package main_clock_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] CLOCK_CTRL_STATUS_IDX = 8'h2c;
  localparam logic [7:0] TONE_CTRL_IDX = 8'h2d;
  localparam int ADR_W = 10;
  // ----------------------------------------
  // Field positions of clock_ctrl_status and the tone register
  // ----------------------------------------
  localparam int CLOCK_OUT_SELECT_BIT = 7;
  localparam int SLOW_DIVIDER_LSB = 5;
  localparam int SLOW_MODE_SELECT_BIT = 4;
  localparam int TIME_BASE_LSB = 2;
  localparam int TICK_IRQ_ENABLE_BIT = 1;
  localparam int TICK_FLAG_BIT = 0;
  localparam int TONE_SELECT_LSB = 0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CLOCK_CTRL_STATUS_RST = 8'h00;
  localparam logic [1:0] TONE_CTRL_RST = 2'h0;
  // ----------------------------------------
  // Timing counts in osc_clock cycles, and the rates in Hz they are worked out from
  // ----------------------------------------
  localparam int TB_DIV0 = 16000;
  localparam int TB_DIV1 = 32000;
  localparam int TB_DIV2 = 80000;
  localparam int TB_DIV3 = 200000;
  localparam int OSC_HZ = 8000000;
  localparam int TONE1_HZ = 2000;
  localparam int TONE2_HZ = 1000;
  localparam int TONE3_HZ = 500;
  localparam int TONE1_HALF = OSC_HZ / (2 * TONE1_HZ);
  localparam int TONE2_HALF = OSC_HZ / (2 * TONE2_HZ);
  localparam int TONE3_HALF = OSC_HZ / (2 * TONE3_HZ);
  // ----------------------------------------
  // Power states
  // ----------------------------------------
  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_ACTIVE_HALT = 3'b010,
    PWR_HALT = 3'b100
  } pwr_state_t;
endpackage

// File: tb.sv
`timescale 1ns/100ps
module tb;
  import main_clock_pkg::*;
  localparam logic [9:0] ST = {CLOCK_CTRL_STATUS_IDX, 2'h0};
  localparam logic [9:0] TN = {TONE_CTRL_IDX, 2'h0};
  logic clk, rst_b, cyc, stb, we, ack, haltReq, waitReq, wakeReq;
  logic [9:0] adr;
  logic [31:0] wdat, datO;
  logic [3:0] sel = 4'h1;
  logic [7:0] rd;
  logic tickIrq, cpuClkEn, aHalt, fHalt, ckPin, ckOe, tonePin, toneOe;
  logic waitMode, haltExec, haltExitWake;
  int n_mismatch = 0, tests_run = 0, cycNo = 0;
  int t0, t1, en, tg, ck, ones, i, c, prevDiv;
  // Short counts keep the run brief
  localparam int TD0 = 20;
  localparam int TD1 = 30;
  localparam int TD2 = 40;
  localparam int TD3 = 50;
  localparam int TH1 = 4;
  localparam int TH2 = 6;
  localparam int TH3 = 8;
  int div[4] = '{TD0, TD1, TD2, TD3};
  int ord[4] = '{3, 1, 2, 0};
  main_clock_ctrl_tick_tone #(.TB_DIV_0(TD0), .TB_DIV_1(TD1),
    .TB_DIV_2(TD2), .TB_DIV_3(TD3), .TONE_HALF_1(TH1), .TONE_HALF_2(TH2),
    .TONE_HALF_3(TH3))
  main_clock_ctrl_tick_tone_inst (.clk(clk), .rst_b(rst_b), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(datO), .wb_ack_o(ack), .waitMode(waitMode),
    .haltExec(haltExec), .haltExitWake(haltExitWake), .tickIrq(tickIrq),
    .cpuClkEn(cpuClkEn), .activeHalt(aHalt), .fullHalt(fHalt),
    .clockOutPin(ckPin), .clockOutOe(ckOe), .tonePin(tonePin),
    .toneOe(toneOe));
  cpu_power_model cpu_power_model_inst (.clk(clk), .rst_b(rst_b),
    .tickIrq(tickIrq), .activeHalt(aHalt), .fullHalt(fHalt),
    .haltReq(haltReq), .waitReq(waitReq), .wakeReq(wakeReq),
    .waitMode(waitMode), .haltExec(haltExec), .haltExitWake(haltExitWake));
  // ----------------------------------------
  // Clock, cycle count, shared tasks
  // ----------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cycNo <= cycNo + 1;
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle; holds until ack is sampled
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'h1 && n < 20);
    rd = datO[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 20) n_mismatch++;
  endtask
  // Waits for a fresh rise of the tick request
  task automatic waitIrq(output int t);
    int n;
    for (n = 0; n < 300 && tickIrq !== 1'h0; n++) @(posedge clk);
    for (n = 0; n < 300 && tickIrq !== 1'h1; n++) @(posedge clk);
    t = cycNo;
    if (n >= 300) n_mismatch++;
  endtask
  // Rise from a real tick: a stale flag is read away first,
  // twice, since a tick on the clearing read keeps the flag
  task automatic syncTick(output int t);
    waitIrq(t);
    xfer(0, ST, 0);
    xfer(0, ST, 0);
    waitIrq(t);
  endtask
  // Counts cpu pulses and pin toggles over w cycles
  task automatic measure(input int s, input int w);
    logic tp, cp;
    en = 0;
    tg = 0;
    ck = 0;
    repeat (s) @(posedge clk);
    tp = tonePin;
    cp = ckPin;
    repeat (w)
    begin
      @(posedge clk);
      en += cpuClkEn;
      tg += (tonePin !== tp);
      ck += (ckPin !== cp);
      tp = tonePin;
      cp = ckPin;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, far past the expected length
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    {cyc, stb, we, adr, wdat, haltReq, waitReq, wakeReq} = '0;
    rst_b = 1'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    xfer(0, ST, 0);
    check("status reset", rd, 8'h00);
    xfer(0, TN, 0);
    check("tone reset", rd, 8'h00);
    xfer(1, ST, 8'he7);
    xfer(0, ST, 0);
    check("status fields", rd & 8'hfe, 8'he6);
    xfer(1, TN, 8'h03);
    xfer(0, TN, 0);
    check("tone fields", rd, 8'h03);
    // Write without the low byte lane is dropped
    sel <= 4'h0;
    xfer(1, TN, 8'h00);
    sel <= 4'h1;
    xfer(0, TN, 0);
    check("byte lane", rd, 8'h03);
    xfer(1, 10'h0b8, 8'hff);
    xfer(0, 10'h0b8, 0);
    check("unmapped", rd, 8'h00);
    $display("test registers done");
    // Every divider code, tone fixed at the fast code
    xfer(1, TN, 8'h01);
    for (i = 0; i < 5; i++)
    begin
      c = (i < 4) ? (24 >> i) : 48;
      xfer(1, ST, (i < 4) ? {1'h1, i[1:0], 5'h10} : 8'h80);
      measure(20, 48);
      check("cpu pulses", en, c);
      check("clock out", ck, c);
      check("clock out enable", ckOe, 1'h1);
      check("tone independent", tg, 12);
    end
    for (i = 0; i < 4; i++)
    begin
      xfer(1, TN, i[7:0]);
      measure(20, 48);
      check("tone toggles", tg, (i == 0) ? 0 : 48 / (2 * i + 2));
      check("tone enable", toneOe, i != 0);
    end
    $display("test clocks done");
    // Select written mid-period: old period completes first
    xfer(1, ST, 8'h02);
    syncTick(t0);
    xfer(0, ST, 0);
    check("flag set", rd[0], 1'h1);
    prevDiv = 20;
    for (i = 0; i < 4; i++)
    begin
      c = ord[i];
      xfer(1, ST, {4'h0, c[1:0], 2'h2});
      waitIrq(t1);
      check("old period", t1 - t0, prevDiv);
      xfer(0, ST, 0);
      t0 = t1;
      waitIrq(t1);
      check("tick period", t1 - t0, div[c]);
      xfer(0, ST, 0);
      t0 = t1;
      prevDiv = div[c];
    end
    xfer(1, ST, 8'h00);
    repeat (45) @(posedge clk);
    check("request masked", tickIrq, 1'h0);
    xfer(0, ST, 0);
    check("flag without enable", rd[0], 1'h1);
    xfer(0, ST, 0);
    check("flag cleared", rd[0], 1'h0);
    // Reads at every phase of the tick: no tick lost
    xfer(1, ST, 8'h02);
    syncTick(t0);
    ones = 0;
    repeat (60)
    begin
      xfer(0, ST, 0);
      ones += rd[0];
    end
    while ((cycNo - t0) % 20 != 10) @(posedge clk);
    t1 = cycNo;
    xfer(0, ST, 0);
    ones += rd[0];
    check("ticks kept", ones, (t1 - t0) / 20 + 1);
    $display("test tick done");
    // Active halt: counter runs, core and registers frozen
    xfer(1, TN, 8'h01);
    xfer(1, ST, 8'h8e);
    syncTick(t0);
    xfer(0, ST, 0);
    @(posedge clk) haltReq <= 1'h1;
    @(posedge clk) haltReq <= 1'h0;
    repeat (3) @(posedge clk);
    check("active halt", aHalt, 1'h1);
    measure(0, 24);
    check("halt cpu", en, 0);
    check("halt tone", tg, 6);
    xfer(1, TN, 8'h00);
    for (i = 0; i < 60 && aHalt === 1'h1; i++) @(posedge clk);
    check("tick wake", aHalt, 1'h0);
    xfer(0, TN, 0);
    check("frozen register", rd, 8'h01);
    // Full halt: everything stops until the external wake
    xfer(1, ST, 8'h80);
    xfer(0, ST, 0);
    @(posedge clk) haltReq <= 1'h1;
    @(posedge clk) haltReq <= 1'h0;
    repeat (3) @(posedge clk);
    check("full halt", fHalt, 1'h1);
    measure(0, 60);
    check("stopped cpu", en, 0);
    check("stopped tone", tg, 0);
    xfer(0, ST, 0);
    check("counter frozen", rd[0], 1'h0);
    @(posedge clk) wakeReq <= 1'h1;
    @(posedge clk) wakeReq <= 1'h0;
    repeat (3) @(posedge clk);
    check("halt exit", fHalt, 1'h0);
    // Wait: all keeps running, tick ends it
    xfer(1, ST, 8'h02);
    waitIrq(t0);
    xfer(0, ST, 0);
    @(posedge clk) waitReq <= 1'h1;
    @(posedge clk) waitReq <= 1'h0;
    xfer(1, TN, 8'h02);
    xfer(0, TN, 0);
    check("wait access", rd, 8'h02);
    for (i = 0; i < 60 && waitMode === 1'h1; i++) @(posedge clk);
    check("wait exit", waitMode, 1'h0);
    $display("test power done");
    final_report();
  end
endmodule
